// ---- rtl/rcic_defines.svh ----
`ifndef RCIC_DEFINES_SVH
`define RCIC_DEFINES_SVH

// number of interrupt sources handled by the block
`define RCIC_NUM_SOURCES        10

// register byte addresses
`define RCIC_ADDR_MASK_CTRL     32'h4000000c
`define RCIC_ADDR_MASKED_STAT   32'h40000010
`define RCIC_ADDR_RAW_STAT      32'h40000014
`define RCIC_ADDR_ACK           32'h40000018

// source bit positions, shared by control, status and acknowledge registers; bit 15 is the tick gate enable, in the control register only
`define RCIC_BIT_BASE_TICK      0
`define RCIC_BIT_RECEIVE        1
`define RCIC_BIT_SLEEP_END      2
`define RCIC_BIT_EVENT_END      3
`define RCIC_BIT_CIPHER         4
`define RCIC_BIT_FAULT          5
`define RCIC_BIT_GROSS_TIMER    6
`define RCIC_BIT_FINE_TIMER     7
`define RCIC_BIT_EVENT_ABORT    8
`define RCIC_BIT_SOFT           9
`define RCIC_BIT_TICK_IN_EVENT  15

// reset values
`define RCIC_MASK_RESET         10'h11f
`define RCIC_TICK_IN_EVENT_RESET 1'b1
`define RCIC_STATUS_RESET       10'h000
`define RCIC_READ_DATA_RESET    32'h00000000

`endif

// ---- rtl/rcic_pkg.sv ----
package rcic_pkg;

    typedef enum {
        RCIC_SEL_NONE,
        RCIC_SEL_MASK_CTRL,
        RCIC_SEL_MASKED_STAT,
        RCIC_SEL_RAW_STAT,
        RCIC_SEL_ACK
    } rcic_reg_sel_e;

    typedef struct packed {
        logic ack;
    } rcic_bus_state_s;

    typedef struct packed {
        logic [9:0] pending;
    } rcic_flag_state_s;

    typedef struct packed {
        logic [9:0]  mask;
        logic        tick_in_event_en;
        logic [31:0] read_data;
    } rcic_ctrl_state_s;

endpackage : rcic_pkg

// ---- rtl/rcic_wb_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcic_defines.svh"

module rcic_wb_slave
    import rcic_pkg::*;
(
    input  wire logic        clk_in,      // core bus clock
    input  wire logic        reset_in,    // async reset, active high
    input  wire logic        cyc_in,      // wishbone cycle
    input  wire logic        stb_in,      // wishbone strobe
    input  wire logic [31:0] adr_in,      // byte address
    output logic             ack_out,     // wishbone acknowledge
    output logic             start_out,   // request seen, answer next cycle
    output logic             done_out,    // request completes at this edge
    output rcic_reg_sel_e    sel_out      // decoded register
);

    rcic_bus_state_s state;
    rcic_bus_state_s next_state;
    logic            request;

    assign request   = cyc_in & stb_in;
    assign ack_out   = state.ack;
    // ack drops in the cycle after it was given, so every access costs two cycles
    assign start_out = request & ~state.ack;
    assign done_out  = request & state.ack;

    always_comb begin
        if (adr_in == `RCIC_ADDR_MASK_CTRL) begin
            sel_out = RCIC_SEL_MASK_CTRL;
        end else if (adr_in == `RCIC_ADDR_MASKED_STAT) begin
            sel_out = RCIC_SEL_MASKED_STAT;
        end else if (adr_in == `RCIC_ADDR_RAW_STAT) begin
            sel_out = RCIC_SEL_RAW_STAT;
        end else if (adr_in == `RCIC_ADDR_ACK) begin
            sel_out = RCIC_SEL_ACK;
        end else begin
            sel_out = RCIC_SEL_NONE;
        end
    end

    always_comb begin
        next_state     = state;
        next_state.ack = start_out;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : rcic_wb_slave

`default_nettype wire

// ---- rtl/rcic_flag_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcic_defines.svh"

module rcic_flag_bank
    import rcic_pkg::*;
(
    input  wire logic       clk_in,       // core bus clock
    input  wire logic       reset_in,     // async reset, active high
    input  wire logic [9:0] set_in,       // one-cycle event pulses
    input  wire logic [9:0] clear_in,     // one-cycle clear pulses
    output logic      [9:0] pending_out   // sticky pending flags
);

    rcic_flag_state_s state;
    rcic_flag_state_s next_state;
    logic [9:0]       next_bit;

    genvar i;
    generate
        for (i = 0; i < `RCIC_NUM_SOURCES; i = i + 1) begin : g_flag
            // a set in the clearing cycle wins so no event is lost
            assign next_bit[i] = set_in[i] | (state.pending[i] & ~clear_in[i]);
        end
    endgenerate

    always_comb begin
        next_state         = state;
        next_state.pending = next_bit;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state.pending <= `RCIC_STATUS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign pending_out = state.pending;

endmodule : rcic_flag_bank

`default_nettype wire

// ---- rtl/rcic_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcic_defines.svh"

module rcic_top
    import rcic_pkg::*;
(
    input  wire logic        clk_in,                 // core bus clock, 25 MHz
    input  wire logic        reset_in,               // async reset, active high
    input  wire logic        wb_cyc_in,              // wishbone cycle
    input  wire logic        wb_stb_in,              // wishbone strobe
    input  wire logic        wb_we_in,               // wishbone write enable
    input  wire logic [31:0] wb_adr_in,              // wishbone byte address
    input  wire logic [3:0]  wb_sel_in,              // wishbone byte lanes
    input  wire logic [31:0] wb_dat_in,              // wishbone write data
    output logic      [31:0] wb_dat_out,             // wishbone read data
    output logic             wb_ack_out,             // wishbone acknowledge
    input  wire logic [9:0]  source_event_in,        // raw event pulses, one per source
    input  wire logic [9:0]  source_ack_in,          // acknowledge strobes from core logic
    input  wire logic        radio_event_active_in,  // a radio event is in progress
    output logic      [9:0]  masked_status_out,      // masked pending flags
    output logic             irq_out                 // level interrupt request
);

    rcic_ctrl_state_s state;
    rcic_ctrl_state_s next_state;

    logic          bus_start;
    logic          bus_done;
    rcic_reg_sel_e bus_sel;
    logic          write_done;
    logic [9:0]    pending;
    logic [9:0]    sw_clear;
    logic [9:0]    all_clear;
    logic [9:0]    event_gate;
    logic [9:0]    masked;
    logic [31:0]   ctrl_word;
    logic [31:0]   masked_word;
    logic [31:0]   raw_word;
    logic [31:0]   read_word;

    rcic_wb_slave u_bus (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .cyc_in    (wb_cyc_in),
        .stb_in    (wb_stb_in),
        .adr_in    (wb_adr_in),
        .ack_out   (wb_ack_out),
        .start_out (bus_start),
        .done_out  (bus_done),
        .sel_out   (bus_sel)
    );

    // writes take effect only at the edge where the master sees ack
    assign write_done = bus_done & wb_we_in;

    // acknowledge register: write one clears, low two byte lanes hold the ten bits
    always_comb begin
        sw_clear = 10'h000;
        if (write_done && (bus_sel == RCIC_SEL_ACK)) begin
            if (wb_sel_in[0]) begin
                sw_clear[7:0] = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
                sw_clear[9:8] = wb_dat_in[9:8];
            end
        end
    end

    // clears from software and from the core both drop the raw and masked bit
    assign all_clear = sw_clear | source_ack_in;

    rcic_flag_bank u_flags (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .set_in      (source_event_in),
        .clear_in    (all_clear),
        .pending_out (pending)
    );

    // the base tick keeps its raw flag during radio events; with tick_in_event_en
    // clear only its delivery is held back, so software still sees ticks it missed
    always_comb begin
        event_gate = 10'h3ff;
        event_gate[`RCIC_BIT_BASE_TICK] =
            ~(radio_event_active_in & ~state.tick_in_event_en);
    end

    assign masked = pending & state.mask & event_gate;

    // register images; bits above the documented fields read zero
    always_comb begin
        ctrl_word                         = 32'h00000000;
        ctrl_word[9:0]                    = state.mask;
        ctrl_word[`RCIC_BIT_TICK_IN_EVENT] = state.tick_in_event_en;
        // bits 14:10 stay zero
    end

    always_comb begin
        masked_word      = 32'h00000000;
        masked_word[9:0] = masked;
    end

    always_comb begin
        raw_word      = 32'h00000000;
        raw_word[9:0] = pending;
    end

    // read mux; unmapped addresses and the acknowledge register read zero
    always_comb begin
        if (bus_sel == RCIC_SEL_MASK_CTRL) begin
            read_word = ctrl_word;
        end else if (bus_sel == RCIC_SEL_MASKED_STAT) begin
            read_word = masked_word;
        end else if (bus_sel == RCIC_SEL_RAW_STAT) begin
            read_word = raw_word;
        end else begin
            read_word = 32'h00000000;
        end
    end

    always_comb begin
        next_state = state;
        if (bus_start && !wb_we_in) begin
            next_state.read_data = read_word;
        end
        if (write_done && (bus_sel == RCIC_SEL_MASK_CTRL)) begin
            if (wb_sel_in[0]) begin
                next_state.mask[7:0] = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
                next_state.mask[9:8] = wb_dat_in[9:8];
                next_state.tick_in_event_en =
                    wb_dat_in[`RCIC_BIT_TICK_IN_EVENT];
            end
        end
        // writes to either status register are ignored
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state.mask             <= `RCIC_MASK_RESET;
            state.tick_in_event_en <= `RCIC_TICK_IN_EVENT_RESET;
            state.read_data        <= `RCIC_READ_DATA_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign wb_dat_out        = state.read_data;
    assign masked_status_out = masked;
    // level held while any masked flag is pending, not a pulse
    assign irq_out           = |masked;

endmodule : rcic_top

`default_nettype wire

// ---- verification/rcic_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcic_defines.svh"
module rcic_top_monitor
(
    input wire logic        clk_in,                // clock
    input wire logic        reset_in,              // reset
    input wire logic        wb_cyc_in,             // cycle
    input wire logic        wb_stb_in,             // strobe
    input wire logic        wb_we_in,              // write
    input wire logic [31:0] wb_adr_in,             // address
    input wire logic [3:0]  wb_sel_in,             // lanes
    input wire logic [31:0] wb_dat_in,             // wdata
    input wire logic [31:0] wb_dat_out,            // rdata
    input wire logic        wb_ack_out,            // ack
    input wire logic [9:0]  source_event_in,       // events
    input wire logic [9:0]  source_ack_in,         // clears
    input wire logic        radio_event_active_in, // radio busy
    input wire logic [9:0]  masked_status_out,     // masked
    input wire logic        irq_out                // irq
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_rd(a);
        wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in && wb_adr_in == a;
    endsequence
    // bit 0 left out: the radio event gate may move it without any flag change
    property p_hold;
        !(wb_ack_out && wb_we_in) |=> ((masked_status_out & $past(masked_status_out
            & ~source_ack_in & 10'h3fe)) == $past(masked_status_out & ~source_ack_in & 10'h3fe));
    endproperty
    property p_no_spur;
        $past(wb_ack_out && wb_we_in) || ((masked_status_out & ~$past(masked_status_out)
            & ~$past(source_event_in) & 10'h3fe) == 10'h000);
    endproperty
    property p_ack_clr;
        (source_ack_in & ~source_event_in) != 10'h000
            |=> (masked_status_out & $past(source_ack_in & ~source_event_in)) == 10'h000;
    endproperty
    property p_irq_or;
        irq_out == |masked_status_out;
    endproperty
    property p_ack_rd0;
        s_rd(`RCIC_ADDR_ACK) |=> wb_ack_out && wb_dat_out == 32'h00000000;
    endproperty
    property p_ctrl_rsvd;
        s_rd(`RCIC_ADDR_MASK_CTRL) |=> wb_ack_out && wb_dat_out[14:10] == 5'h00;
    endproperty
    property p_stat_top;
        s_rd(`RCIC_ADDR_MASKED_STAT) or s_rd(`RCIC_ADDR_RAW_STAT) |=> wb_dat_out[31:10] == 22'h0;
    endproperty
    property p_rst_clear;
        $fell(reset_in) |-> masked_status_out == 10'h000 && !irq_out && !wb_ack_out;
    endproperty
    a_hold: assert property (p_hold) else $error("pending flag lost");
    a_no_spur: assert property (p_no_spur) else $error("flag without event");
    a_ack_clr: assert property (p_ack_clr) else $error("clear ignored");
    a_irq_or: assert property (p_irq_or) else $error("irq not OR");
    a_ack_rd0: assert property (p_ack_rd0) else $error("ack reg not 0");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");
    a_stat_top: assert property (p_stat_top) else $error("status top bits set");
    a_rst_clear: assert property (p_rst_clear) else $error("not clear at reset");
endmodule : rcic_top_monitor
`default_nettype wire

// ---- verification/rcic_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcic_defines.svh"
module rcic_top_tb;
    localparam logic [9:0] mask_rst = 10'h11f;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, radio = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, rdat, q;
    logic        ack, irq;
    logic [9:0]  ev = 10'h0, sack = 10'h0, mstat;
    int          n_errors = 0, compares = 0;
    always #20 clk_in = ~clk_in;
    rcic_top dut (.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .source_event_in(ev), .source_ack_in(sack),
        .radio_event_active_in(radio), .masked_status_out(mstat), .irq_out(irq));
    task check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : check
    // ack and read data are taken at the rising edge where ack is seen high,
    // and the request is only released at that same edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_in); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask : rd
    task pulse(input logic [9:0] v);
        @(posedge clk_in);
        ev <= v;
        @(posedge clk_in);
        ev <= 10'h0;
    endtask : pulse
    task irq_is(input logic e);
        @(negedge clk_in);
        check({31'h0, irq}, {31'h0, e});
    endtask : irq_is
    task summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(`RCIC_ADDR_MASK_CTRL, 32'h0000811f);
        rd(`RCIC_ADDR_RAW_STAT, 32'h0);
        for (int i = 0; i < 10; i++) begin
            pulse(10'h1 << i);
            rd(`RCIC_ADDR_RAW_STAT, 32'h1 << i);
            rd(`RCIC_ADDR_MASKED_STAT, (32'h1 << i) & 32'h11f);
            irq_is(mask_rst[i]);
            check({22'h0, mstat}, (32'h1 << i) & 32'h11f);
            bus(1'b1, `RCIC_ADDR_ACK, 32'h1 << i);
            rd(`RCIC_ADDR_RAW_STAT, 32'h0);
        end
        $display("test sources done");
        bus(1'b1, `RCIC_ADDR_MASK_CTRL, 32'hffffffff);
        rd(`RCIC_ADDR_MASK_CTRL, 32'h000083ff);
        bus(1'b1, `RCIC_ADDR_MASKED_STAT, 32'h3ff);
        rd(`RCIC_ADDR_RAW_STAT, 32'h0);
        rd(`RCIC_ADDR_ACK, 32'h0);
        rd(32'h40000040, 32'h0);
        pulse(10'h020);
        bus(1'b1, `RCIC_ADDR_MASK_CTRL, 32'h0);
        irq_is(1'b0);
        rd(`RCIC_ADDR_RAW_STAT, 32'h20);
        bus(1'b1, `RCIC_ADDR_MASK_CTRL, 32'h20);
        irq_is(1'b1);
        @(posedge clk_in);
        sack <= 10'h020;
        @(posedge clk_in);
        sack <= 10'h0;
        rd(`RCIC_ADDR_RAW_STAT, 32'h0);
        $display("test masks done");
        bus(1'b1, `RCIC_ADDR_MASK_CTRL, 32'h3ff);
        radio <= 1'b1;
        pulse(10'h001);
        rd(`RCIC_ADDR_MASKED_STAT, 32'h0);
        rd(`RCIC_ADDR_RAW_STAT, 32'h1);
        irq_is(1'b0);
        bus(1'b1, `RCIC_ADDR_MASK_CTRL, 32'h83ff);
        rd(`RCIC_ADDR_MASKED_STAT, 32'h1);
        irq_is(1'b1);
        $display("test tick gate done");
        summarize();
    end
endmodule : rcic_top_tb
bind rcic_top rcic_top_monitor u_mon (.clk_in(clk_in), .reset_in(reset_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .source_event_in(source_event_in), .source_ack_in(source_ack_in),
    .radio_event_active_in(radio_event_active_in), .masked_status_out(masked_status_out),
    .irq_out(irq_out));
`default_nettype wire
